// >>> fsbsb_pkg.sv
// Purpose: shared constants for the bus sideband (interrupts, lock, error line)
// Assumes: one 40 MHz clock, all pins synchronous except the interrupt inputs
// Notes: error line is modelled as drive-low enable plus combined level
package fsbsb_pkg;
    localparam int CLOCK_MHZ = 40;
    localparam int EDGE_DIV = 2;
    localparam logic [0:0] EDGE_CNT_RESET = 1'h0;
    localparam logic [0:0] EDGE_CNT_LAST = 1'(EDGE_DIV - 1);
    localparam logic LOCAL_CTRL_EN_RESET = 1'h1;
    localparam logic ERR_EN_RESET = 1'h0;
    localparam int IRQ_ZERO_BIT = 0;
    localparam int IRQ_ONE_BIT = 1;
    typedef enum logic [1:0] {
        FSBSB_LK_IDLE,
        FSBSB_LK_HOLD,
        FSBSB_LK_WAIT
    } fsbsb_lock_t;
endpackage

// >>> fsbsb_if.sv
// Purpose: shared sideband wires between the device and a peer or priority agent
// Assumes: error line is wire-OR, asserted low when any enable is high
// Notes: lock and priority request are active low levels
`timescale 1ns/1ps
interface fsbsb_if (
    input wire logic clock
);
    logic [1:0] localIrqIn;
    logic lockDevN;
    logic lockPeerN;
    logic priorityReqN;
    logic mcerrDevOe;
    logic mcerrPeerOe;
    logic machineCheckErrN;
    logic edgeTick;
    assign machineCheckErrN = ~(mcerrDevOe | mcerrPeerOe);
    modport device (
        input clock, localIrqIn, lockPeerN, priorityReqN, machineCheckErrN, edgeTick,
        output lockDevN, mcerrDevOe
    );
    modport agent (
        input clock, lockDevN, machineCheckErrN,
        output localIrqIn, lockPeerN, priorityReqN, mcerrPeerOe, edgeTick
    );
endinterface

// >>> fsbsb_sync.sv
// Purpose: two-stage synchroniser for a vector of asynchronous inputs
// Assumes: stage one is read only by stage two
// Notes: reset value low
`timescale 1ns/1ps
module fsbsb_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stageOne;
    logic [WIDTH-1:0] next_stageOne;
    logic [WIDTH-1:0] next_syncOut;
    always_comb begin
        next_stageOne = asyncIn;
        next_syncOut = stageOne;
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            stageOne <= '0;
            syncOut <= '0;
        end else begin
            stageOne <= next_stageOne;
            syncOut <= next_syncOut;
        end
    end
endmodule

// >>> fsbsb_device.sv
// Purpose: device end of the sideband: interrupt inputs, bus lock, error line
// Assumes: edgeTick marks the designated bus edges for the wire-OR line
// Notes: configuration arrives on one-cycle write strobes
//        lock and error pins leave straight from flops
// Function
// - controller off: input zero is maskable request
// - controller off: input one is nonmaskable
// - interrupt inputs synchronised internally
// - controller enabled after reset, software selects
// - lock held across whole locked sequence
// - priority agent waits for lock release
// - owner keeps bus through locked operation
// - error line reports unrecoverable errors
// - error line assertion enable configurable
// - internal error asserts line with output
// - initiator asserts line on observed error
// - any observer of bus error asserts
// - error line is wire-OR, drive low only
// - drive and sample on designated edges
// - internal error held until reset or init
`timescale 1ns/1ps
module fsbsb_device (
    input wire logic clock,
    input wire logic rstn,
    fsbsb_if.device bus,
    input wire logic localCtrlEnable,
    input wire logic localCtrlWrite,
    input wire logic errLineEnable,
    input wire logic errLineWrite,
    input wire logic errInternal,
    input wire logic errInitiator,
    input wire logic errObserved,
    input wire logic lockStart,
    input wire logic lockEnd,
    input wire logic initN,
    input wire logic busInitN,
    output logic localCtrlOn,
    output logic [1:0] localIrqOut,
    output logic maskableIrqReq,
    output logic nonmaskableIrq,
    output logic internalErrN,
    output logic errLineSeen,
    output logic lockActive,
    output logic busHeldByPriority
);
    logic [1:0] irqSync;
    logic errEnable;
    logic next_localCtrlOn;
    logic next_errEnable;
    logic [1:0] next_localIrqOut;
    logic next_maskableIrqReq;
    logic next_nonmaskableIrq;
    logic next_internalErrN;
    logic next_errLineSeen;
    logic next_lockActive;
    logic next_busHeldByPriority;
    logic mcerrOe;
    logic next_mcerrOe;
    logic errPending;
    logic next_errPending;
    fsbsb_pkg::fsbsb_lock_t lockState;
    fsbsb_pkg::fsbsb_lock_t next_lockState;
    logic [1:0] next_legacyIrq;
    logic lockN;
    logic next_lockN;

    fsbsb_sync #(
        .WIDTH(2)
    ) irqSyncInst (
        .clock(clock),
        .rstn(rstn),
        .asyncIn(bus.localIrqIn),
        .syncOut(irqSync)
    );

    // configuration written by one-cycle strobes; both bits hold until rewritten
    always_comb begin
        next_localCtrlOn = localCtrlWrite ? localCtrlEnable : localCtrlOn;
        next_errEnable = errLineWrite ? errLineEnable : errEnable;
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            localCtrlOn <= fsbsb_pkg::LOCAL_CTRL_EN_RESET;
            errEnable <= fsbsb_pkg::ERR_EN_RESET;
        end else begin
            localCtrlOn <= next_localCtrlOn;
            errEnable <= next_errEnable;
        end
    end

    // each lane feeds the controller or its legacy pin, never both
    for (genvar lane = 0; lane < 2; lane++) begin : g_lane
        assign next_localIrqOut[lane] = localCtrlOn && irqSync[lane];
        assign next_legacyIrq[lane] = !localCtrlOn && irqSync[lane];
    end

    // interrupt routing by controller mode
    always_comb begin
        next_maskableIrqReq = next_legacyIrq[fsbsb_pkg::IRQ_ZERO_BIT];
        next_nonmaskableIrq = next_legacyIrq[fsbsb_pkg::IRQ_ONE_BIT];
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            localIrqOut <= 2'h0;
            maskableIrqReq <= 1'h0;
            nonmaskableIrq <= 1'h0;
        end else begin
            localIrqOut <= next_localIrqOut;
            maskableIrqReq <= next_maskableIrqReq;
            nonmaskableIrq <= next_nonmaskableIrq;
        end
    end

    // lock: a sequence cannot start while the priority agent holds the bus
    always_comb begin
        next_lockState = lockState;
        case (lockState)
            fsbsb_pkg::FSBSB_LK_IDLE: begin
                if (lockStart && !bus.priorityReqN) begin
                    next_lockState = fsbsb_pkg::FSBSB_LK_WAIT;
                end else if (lockStart) begin
                    next_lockState = fsbsb_pkg::FSBSB_LK_HOLD;
                end
            end
            fsbsb_pkg::FSBSB_LK_WAIT: begin
                // hold off until the priority agent drops its request
                if (bus.priorityReqN) begin
                    next_lockState = fsbsb_pkg::FSBSB_LK_HOLD;
                end
            end
            fsbsb_pkg::FSBSB_LK_HOLD: begin
                // priority request ignored here so atomicity holds
                if (lockEnd) begin
                    next_lockState = fsbsb_pkg::FSBSB_LK_IDLE;
                end
            end
            default: next_lockState = fsbsb_pkg::FSBSB_LK_IDLE;
        endcase
        next_lockActive = (next_lockState == fsbsb_pkg::FSBSB_LK_HOLD);
        next_lockN = !next_lockActive;
        // priority agent owns the bus only while no lock is up
        next_busHeldByPriority = !bus.priorityReqN && bus.lockPeerN
            && (lockState != fsbsb_pkg::FSBSB_LK_HOLD);
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            lockState <= fsbsb_pkg::FSBSB_LK_IDLE;
            lockActive <= 1'h0;
            lockN <= 1'h1;
            busHeldByPriority <= 1'h0;
        end else begin
            lockState <= next_lockState;
            lockActive <= next_lockActive;
            lockN <= next_lockN;
            busHeldByPriority <= next_busHeldByPriority;
        end
    end
    assign bus.lockDevN = lockN;

    // sticky internal error; a new error outranks a clear in the same cycle
    always_comb begin
        next_internalErrN = internalErrN;
        if (errInternal) begin
            next_internalErrN = 1'h0;
        end else if (!initN || !busInitN) begin
            next_internalErrN = 1'h1;
        end
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            internalErrN <= 1'h1;
        end else begin
            internalErrN <= next_internalErrN;
        end
    end

    // error line: events latch until a designated edge, then drive low
    always_comb begin
        next_errPending = errPending;
        // set wins over the clearing edge
        if (errEnable && (errInternal || errInitiator || errObserved)) begin
            next_errPending = 1'h1;
        end else if (bus.edgeTick) begin
            next_errPending = 1'h0;
        end
        // change only at a designated edge so peers never see a glitch
        next_mcerrOe = bus.edgeTick ? (errPending && errEnable) : mcerrOe;
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            errPending <= 1'h0;
            mcerrOe <= 1'h0;
        end else begin
            errPending <= next_errPending;
            mcerrOe <= next_mcerrOe;
        end
    end
    assign bus.mcerrDevOe = mcerrOe;

    // combined line level, read only at designated edges
    always_comb begin
        next_errLineSeen = bus.edgeTick ? !bus.machineCheckErrN : errLineSeen;
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            errLineSeen <= 1'h0;
        end else begin
            errLineSeen <= next_errLineSeen;
        end
    end
endmodule

// >>> fsbsb_agent.sv
// Purpose: far end: peer or priority agent on the shared sideband
// Assumes: divider sets the designated edges for the wire-OR line
// Notes: interrupt lines driven from flops, no bus alignment needed by device
`timescale 1ns/1ps
module fsbsb_agent (
    input wire logic clock,
    input wire logic rstn,
    fsbsb_if.agent bus,
    input wire logic [1:0] irqDrive,
    input wire logic wantBus,
    input wire logic peerLock,
    input wire logic errObserved,
    output logic ownsBus,
    output logic errLineSeen
);
    logic [1:0] irqReg;
    logic prioReqN;
    logic peerLockN;
    logic errOe;
    logic edgeCnt;
    logic tick;
    logic errPending;
    logic [1:0] next_irqReg;
    logic next_prioReqN;
    logic next_peerLockN;
    logic next_errOe;
    logic next_edgeCnt;
    logic next_tick;
    logic next_errPending;
    logic next_ownsBus;
    logic next_errLineSeen;

    always_comb begin
        next_irqReg = irqDrive;
        next_peerLockN = !peerLock;
        next_prioReqN = !wantBus;
        // ownership only once the lock line is released
        next_ownsBus = wantBus && !prioReqN && bus.lockDevN;
        next_edgeCnt = (edgeCnt == fsbsb_pkg::EDGE_CNT_LAST) ? fsbsb_pkg::EDGE_CNT_RESET
            : edgeCnt + 1'h1;
        next_tick = (edgeCnt == fsbsb_pkg::EDGE_CNT_LAST);
        next_errPending = errObserved ? 1'h1 : (tick ? 1'h0 : errPending);
        next_errOe = tick ? errPending : errOe;
        next_errLineSeen = tick ? !bus.machineCheckErrN : errLineSeen;
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            irqReg <= 2'h0;
            prioReqN <= 1'h1;
            peerLockN <= 1'h1;
            ownsBus <= 1'h0;
            edgeCnt <= fsbsb_pkg::EDGE_CNT_RESET;
            tick <= 1'h0;
            errPending <= 1'h0;
            errOe <= 1'h0;
            errLineSeen <= 1'h0;
        end else begin
            irqReg <= next_irqReg;
            prioReqN <= next_prioReqN;
            peerLockN <= next_peerLockN;
            ownsBus <= next_ownsBus;
            edgeCnt <= next_edgeCnt;
            tick <= next_tick;
            errPending <= next_errPending;
            errOe <= next_errOe;
            errLineSeen <= next_errLineSeen;
        end
    end
    assign bus.localIrqIn = irqReg;
    assign bus.priorityReqN = prioReqN;
    assign bus.lockPeerN = peerLockN;
    assign bus.mcerrPeerOe = errOe;
    assign bus.edgeTick = tick;
endmodule

// >>> fsbsb_monitor.sv
// Purpose: checks on the shared sideband wires
// Assumes: edgeTick from the agent divider marks the designated edges
// Notes: sees interface signals only
`timescale 1ns/1ps
module fsbsb_monitor (
    input wire logic clock,
    input wire logic rstn,
    input wire logic edgeTick,
    input wire logic lockDevN,
    input wire logic priorityReqN,
    input wire logic mcerrDevOe,
    input wire logic mcerrPeerOe,
    input wire logic machineCheckErrN
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    sequence s_tick_gap;
        !edgeTick ##1 edgeTick;
    endsequence
    property p_tick_period; edgeTick |=> s_tick_gap; endproperty
    property p_dev_edge; $rose(mcerrDevOe) |-> $past(edgeTick); endproperty
    property p_peer_edge; $rose(mcerrPeerOe) |-> $past(edgeTick); endproperty
    property p_dev_hold; $rose(mcerrDevOe) |=> mcerrDevOe; endproperty
    property p_dev_low; mcerrDevOe |-> !machineCheckErrN; endproperty
    property p_peer_low; mcerrPeerOe |-> !machineCheckErrN; endproperty
    property p_idle_high; !(mcerrDevOe || mcerrPeerOe) |-> machineCheckErrN; endproperty
    // lock may only begin while no priority request is pending
    property p_lock_gate; $fell(lockDevN) |-> $past(priorityReqN); endproperty
    a_tick_period: assert property (p_tick_period)
        else $error("edge tick spacing wrong");
    a_dev_edge: assert property (p_dev_edge)
        else $error("device error drive off tick");
    a_peer_edge: assert property (p_peer_edge)
        else $error("agent error drive off tick");
    a_dev_hold: assert property (p_dev_hold)
        else $error("device error drive glitched");
    a_dev_low: assert property (p_dev_low)
        else $error("line high while device drives");
    a_peer_low: assert property (p_peer_low)
        else $error("line high while agent drives");
    a_idle_high: assert property (p_idle_high)
        else $error("line low with no driver");
    a_lock_gate: assert property (p_lock_gate)
        else $error("lock taken under priority request");
endmodule

// >>> testbench.sv
// Purpose: directed tests of device and agent joined by the sideband
// Assumes: inputs change at rising edges, outputs read 1 ns later
// Notes: strobe bits pulse for one cycle
`timescale 1ns/1ps
module testbench;
    localparam int WCTL = 0, WERR = 1, EINT = 2, EINI = 3, EOBS = 4, LKS = 5, LKE = 6, PERR = 7;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic initN = 1'b1;
    logic busInitN = 1'b1;
    logic ctlEn = 1'b0;
    logic errEn = 1'b1;
    logic wantBus = 1'b0;
    logic [1:0] irqDrive = 2'h0;
    logic [7:0] strobe = 8'h00;
    logic localCtrlOn, maskableIrqReq, nonmaskableIrq, internalErrN, errLineSeen, lockActive;
    logic ownsBus, peerSeen, heldByPrio;
    logic [1:0] localIrqOut;
    int num_errors = 0;
    int compares = 0;
    int i, m, k, n;
    always #12.5 clock = ~clock;
    fsbsb_if sb (.clock(clock));
    fsbsb_device fsbsb_device_i (.clock(clock), .rstn(rstn), .bus(sb.device),
        .localCtrlEnable(ctlEn), .localCtrlWrite(strobe[WCTL]), .errLineEnable(errEn),
        .errLineWrite(strobe[WERR]), .errInternal(strobe[EINT]), .errInitiator(strobe[EINI]),
        .errObserved(strobe[EOBS]), .lockStart(strobe[LKS]), .lockEnd(strobe[LKE]),
        .initN(initN), .localCtrlOn(localCtrlOn), .localIrqOut(localIrqOut),
        .maskableIrqReq(maskableIrqReq), .nonmaskableIrq(nonmaskableIrq),
        .internalErrN(internalErrN), .errLineSeen(errLineSeen), .lockActive(lockActive),
        .busInitN(busInitN), .busHeldByPriority(heldByPrio));
    fsbsb_agent fsbsb_agent_i (.clock(clock), .rstn(rstn), .bus(sb.agent), .irqDrive(irqDrive),
        .wantBus(wantBus), .peerLock(1'b0), .errObserved(strobe[PERR]), .ownsBus(ownsBus),
        .errLineSeen(peerSeen));
    fsbsb_monitor fsbsb_monitor_i (.clock(clock), .rstn(rstn), .edgeTick(sb.edgeTick),
        .lockDevN(sb.lockDevN), .priorityReqN(sb.priorityReqN), .mcerrDevOe(sb.mcerrDevOe),
        .mcerrPeerOe(sb.mcerrPeerOe), .machineCheckErrN(sb.machineCheckErrN));
    task cyc(input int c);
        repeat (c) @(posedge clock);
        #1;
    endtask
    task pulse(input int b);
        @(posedge clock) strobe[b] <= 1'b1;
        @(posedge clock) strobe <= 8'h00;
        #1;
    endtask
    task doReset;
        @(posedge clock) rstn <= 1'b0;
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        cyc(1);
    endtask
    task chk(input logic [1:0] got, input logic [1:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task give_verdict;
        $display("compares=%0d num_errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // whole run is some 200 cycles
    initial begin
        #100000;
        num_errors++;
        give_verdict();
    end
    initial begin
        doReset();
        chk(localCtrlOn, 1);
        chk(sb.lockDevN, 1);
        chk(sb.machineCheckErrN, 1);
        for (m = 0; m < 2; m++) begin
            if (m == 1) pulse(WCTL);
            chk(localCtrlOn, m == 0);
            for (i = 1; i < 3; i++) begin
                @(posedge clock) irqDrive <= 2'(i);
                cyc(8);
                chk(localIrqOut, (m == 0) ? 2'(i) : 2'h0);
                chk(maskableIrqReq, m == 1 && i[0]);
                chk(nonmaskableIrq, m == 1 && i[1]);
            end
        end
        @(posedge clock) ctlEn <= 1'b1;
        pulse(WCTL);
        chk(localCtrlOn, 1);
        cyc(1);
        chk(localIrqOut, 2'h2);
        chk(nonmaskableIrq, 0);
        pulse(LKS);
        chk(lockActive, 1);
        chk(sb.lockDevN, 0);
        @(posedge clock) wantBus <= 1'b1;
        cyc(6);
        chk(ownsBus, 0);
        chk(sb.lockDevN, 0);
        chk(heldByPrio, 0);
        pulse(LKE);
        chk(sb.lockDevN, 1);
        for (n = 0; n < 8 && ownsBus !== 1'b1; n++) cyc(1);
        chk(ownsBus, 1);
        chk(heldByPrio, 1);
        pulse(LKS);
        cyc(3);
        chk(lockActive, 0);
        @(posedge clock) wantBus <= 1'b0;
        cyc(3);
        chk(lockActive, 1);
        pulse(LKE);
        chk(sb.lockDevN, 1);
        for (k = EINT; k <= EOBS; k++) begin
            doReset();
            pulse(k);
            cyc(6);
            chk(sb.mcerrDevOe, 0);
            pulse(WERR);
            pulse(k);
            chk(internalErrN, k != EINT);
            for (n = 0; n < 8 && sb.mcerrDevOe !== 1'b1; n++) cyc(1);
            chk(sb.mcerrDevOe, 1);
            chk(sb.machineCheckErrN, 0);
            cyc(2);
            chk(errLineSeen, 1);
            chk(peerSeen, 1);
        end
        doReset();
        chk(internalErrN, 1);
        pulse(WERR);
        pulse(EINT);
        cyc(10);
        chk(internalErrN, 0);
        @(posedge clock) initN <= 1'b0;
        @(posedge clock) initN <= 1'b1;
        cyc(1);
        chk(internalErrN, 1);
        pulse(EINT);
        chk(internalErrN, 0);
        @(posedge clock) busInitN <= 1'b0;
        @(posedge clock) busInitN <= 1'b1;
        cyc(1);
        chk(internalErrN, 1);
        doReset();
        pulse(PERR);
        for (n = 0; n < 8 && errLineSeen !== 1'b1; n++) cyc(1);
        chk(errLineSeen, 1);
        chk(sb.mcerrDevOe, 0);
        pulse(WERR);
        @(posedge clock) errEn <= 1'b0;
        pulse(WERR);
        pulse(EOBS);
        cyc(6);
        chk(sb.mcerrDevOe, 0);
        give_verdict();
    end
endmodule
